/* rtl/itc_defines.vh */
// constants for the reference trim and oscillator range configuration block
`ifndef ITC_DEFINES_VH
`define ITC_DEFINES_VH

// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define ITC_IDX_SLOW_TRIM     8'h02
`define ITC_IDX_RANGE_TRIM    8'h03
`define ITC_IDX_SYNC_STAT     8'h07
`define ITC_ADDR_SLOW_TRIM    8'h08
`define ITC_ADDR_RANGE_TRIM   8'h0C
`define ITC_ADDR_SYNC_STAT    8'h1C

// ----------------------------------------
// field positions of the range and fast trim register
// ----------------------------------------
`define ITC_NARROW_BIT        7
`define ITC_RANGE_HI          6
`define ITC_RANGE_LO          5
`define ITC_FAST_HI           4
`define ITC_FAST_LO           1
`define ITC_SFINE_BIT         0

// ----------------------------------------
// reset values of the fields that have a fixed one
// ----------------------------------------
`define ITC_RANGE_RESET       2'h0
`define ITC_NARROW_RESET      1'h0

// ----------------------------------------
// range codes
// ----------------------------------------
`define ITC_RANGE_LOW         2'h0
`define ITC_RANGE_MID         2'h1
`define ITC_RANGE_MIDHIGH     2'h2
`define ITC_RANGE_HIGH        2'h3

// ----------------------------------------
// multiplication factors, wide reference and 32.768 kHz narrowed
// ----------------------------------------
`define ITC_FACT_WIDE_0       12'h280
`define ITC_FACT_WIDE_1       12'h500
`define ITC_FACT_WIDE_2       12'h780
`define ITC_FACT_WIDE_3       12'hA00
`define ITC_FACT_NARROW_0     12'h2DC
`define ITC_FACT_NARROW_1     12'h5B8
`define ITC_FACT_NARROW_2     12'h895
`define ITC_FACT_NARROW_3     12'hB71

// ----------------------------------------
// timing and bus answers
// ----------------------------------------
`define ITC_SYNC_CYCLES       4
`define ITC_RESP_OKAY         2'h0
`define ITC_RESP_SLVERR       2'h2

`endif

/* rtl/itc_range_sync.v */
// range select synchroniser and multiplication factor lookup
`timescale 1ns/1ns
`default_nettype none
`include "itc_defines.vh"

module itc_range_sync #(
	parameter SYNC_CYCLES = `ITC_SYNC_CYCLES
) (
	// clock and reset
	input  wire       i_clk_sys,
	input  wire       i_rst_n,
	// requested setting
	input  wire [1:0] i_range_select,
	input  wire       i_narrow_max_32k,
	// setting in effect
	output reg  [1:0] o_range_status,
	output reg        o_busy,
	output reg  [11:0] o_fll_factor
);

	reg [7:0] wait_cnt;

	// ----------------------------------------
	// delayed hand-over of a new range
	// ----------------------------------------
	// the status follows only after the count runs out
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_range_status <= `ITC_RANGE_RESET;
			wait_cnt       <= 8'h00;
			o_busy         <= 1'b0;
		end else if (i_range_select != o_range_status) begin
			o_busy <= 1'b1;
			if (wait_cnt == SYNC_CYCLES[7:0] - 8'h01) begin
				o_range_status <= i_range_select;
				wait_cnt       <= 8'h00;
			end else begin
				wait_cnt <= wait_cnt + 8'h01;
			end
		end else begin
			wait_cnt <= 8'h00;
			o_busy   <= 1'b0;
		end
	end

	// ----------------------------------------
	// factor for the range in effect
	// ----------------------------------------
	// looked up from status, not select, so it never runs ahead
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fll_factor <= `ITC_FACT_WIDE_0;
		end else begin
			case ({i_narrow_max_32k, o_range_status})
				3'h0: o_fll_factor <= `ITC_FACT_WIDE_0;
				3'h1: o_fll_factor <= `ITC_FACT_WIDE_1;
				3'h2: o_fll_factor <= `ITC_FACT_WIDE_2;
				3'h3: o_fll_factor <= `ITC_FACT_WIDE_3;
				3'h4: o_fll_factor <= `ITC_FACT_NARROW_0;
				3'h5: o_fll_factor <= `ITC_FACT_NARROW_1;
				3'h6: o_fll_factor <= `ITC_FACT_NARROW_2;
				3'h7: o_fll_factor <= `ITC_FACT_NARROW_3;
				default: o_fll_factor <= `ITC_FACT_WIDE_0;
			endcase
		end
	end

endmodule
`default_nettype wire

/* rtl/itc_trim_cfg.v */
// reference trim and oscillator range configuration, AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "itc_defines.vh"

// ----------------------------------------
// register map, one aligned word each
// ----------------------------------------
// 0x08 slow coarse trim
//   [7:0] coarse trim, binary weighted
// 0x0C range and fast trim
//   [7]   narrow maximum for a 32.768 kHz reference
//   [6:5] write: range select, read: range in effect
//   [4:1] fast trim, binary weighted
//   [0]   slow fine trim
// 0x1C range status, read only
//   [0]   range change still in progress
// unmapped offsets answer with a slave error
// bits 31:8 read as zero and are dropped on write
// address bits 1:0 are ignored
// trim fields hold zero until the factory load

// ----------------------------------------
// bus timing seen by software
// ----------------------------------------
// read data stands from the edge that takes the address
// write response rises on the edge after the later half is taken
// next write is accepted on the edge after the response
// one write and one read may be open at the same time
// the bus stays closed on the first edge after reset release
// a write with strobe bit 0 clear is answered but changes nothing
// range status follows the select after SYNC_CYCLES edges
// the narrowing bit acts at once, only the range is handed over
// a select rewritten mid count is taken at the terminal count

// ----------------------------------------
// limitations
// ----------------------------------------
// factory inputs must be steady on the first edge after release;
// they are caught once and never watched again
// protection bits are accepted and ignored, no access filtering
// only byte lane 0 is honoured, other strobes are ignored
// with ADDR_W above 8 the upper address bits alias onto the map
// a range write with an unchanged code starts no count
// trims act on the oscillators at once, so software must not
// rely on any settling time from this block

module itc_trim_cfg #(
	parameter ADDR_W      = 8,
	parameter SYNC_CYCLES = `ITC_SYNC_CYCLES
) (
	// clock and reset
	input  wire              i_clk_sys,
	input  wire              i_rst_n,
	// factory trim values, caught at reset release
	input  wire [7:0]        i_factory_slow_coarse,
	input  wire              i_factory_slow_fine,
	input  wire [3:0]        i_factory_fast_trim,
	// axi write address channel
	input  wire [ADDR_W-1:0] i_s_axi_awaddr,
	input  wire [2:0]        i_s_axi_awprot,
	input  wire              i_s_axi_awvalid,
	output reg               o_s_axi_awready,
	// axi write data channel
	input  wire [31:0]       i_s_axi_wdata,
	input  wire [3:0]        i_s_axi_wstrb,
	input  wire              i_s_axi_wvalid,
	output reg               o_s_axi_wready,
	// axi write response channel
	output reg  [1:0]        o_s_axi_bresp,
	output reg               o_s_axi_bvalid,
	input  wire              i_s_axi_bready,
	// axi read address channel
	input  wire [ADDR_W-1:0] i_s_axi_araddr,
	input  wire [2:0]        i_s_axi_arprot,
	input  wire              i_s_axi_arvalid,
	output reg               o_s_axi_arready,
	// axi read data channel
	output reg  [31:0]       o_s_axi_rdata,
	output reg  [1:0]        o_s_axi_rresp,
	output reg               o_s_axi_rvalid,
	input  wire              i_s_axi_rready,
	// oscillator controls
	output reg  [7:0]        o_slow_coarse_trim,
	output reg               o_slow_fine_trim,
	output reg  [3:0]        o_fast_ref_trim,
	output reg  [1:0]        o_osc_range_select,
	output reg               o_narrow_max_32k,
	// range in effect and factor
	output wire [1:0]        o_osc_range_status,
	output wire              o_range_busy,
	output wire [11:0]       o_fll_factor
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	// factory load gate
	reg              load_pending;

	// parked write halves
	reg              aw_held;
	reg [ADDR_W-1:0] aw_addr;
	reg              w_held;
	reg [31:0]       w_data;
	reg [3:0]        w_strb;

	// next values of the handshake flops
	reg              next_aw_held;
	reg              next_w_held;
	reg              next_awready;
	reg              next_wready;
	reg              next_bvalid;
	reg              next_arready;
	reg              next_rvalid;

	// address decode results
	reg [31:0]       rd_word;
	reg              rd_hit;
	reg              wr_hit;

	// handshake strobes and indices
	wire             do_write;
	wire             aw_take;
	wire             w_take;
	wire             ar_take;
	wire [5:0]       wr_index;
	wire [5:0]       rd_index;
	wire [7:0]       range_reg_rd;

	// unused protection and upper write data bits, every access is treated alike
	wire             prot_unused;
	assign prot_unused = |{i_s_axi_awprot, i_s_axi_arprot, i_s_axi_wdata[31:8]};

	// ----------------------------------------
	// channel handshakes
	// ----------------------------------------
	// a channel moves on the edge where valid and ready meet
	assign aw_take  = i_s_axi_awvalid & o_s_axi_awready;
	assign w_take   = i_s_axi_wvalid & o_s_axi_wready;
	assign ar_take  = i_s_axi_arvalid & o_s_axi_arready;
	// write commits once both halves are held and no response is pending
	assign do_write = aw_held & w_held & ~o_s_axi_bvalid;
	assign wr_index = aw_addr[7:2];
	assign rd_index = i_s_axi_araddr[7:2];

	// ----------------------------------------
	// write channel sequencing
	// ----------------------------------------
	// address and data may come in either order or together
	always @* begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_bvalid  = o_s_axi_bvalid;
		if (aw_take) begin
			next_aw_held = 1'b1;
		end
		if (w_take) begin
			next_w_held = 1'b1;
		end
		// commit frees both halves and raises the response
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
		end
		// response leaves when the master takes it
		if (o_s_axi_bvalid & i_s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		// no new write is taken until the response has gone
		next_awready = ~next_aw_held & ~next_bvalid & ~load_pending;
		next_wready  = ~next_w_held & ~next_bvalid & ~load_pending;
	end

	// write channel flops
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_held         <= 1'b0;
			w_held          <= 1'b0;
			aw_addr         <= {ADDR_W{1'b0}};
			w_data          <= 32'h00000000;
			w_strb          <= 4'h0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready  <= 1'b0;
			o_s_axi_bvalid  <= 1'b0;
			o_s_axi_bresp   <= `ITC_RESP_OKAY;
		end else begin
			aw_held         <= next_aw_held;
			w_held          <= next_w_held;
			o_s_axi_awready <= next_awready;
			o_s_axi_wready  <= next_wready;
			o_s_axi_bvalid  <= next_bvalid;
			// halves are parked until both have arrived
			if (aw_take) begin
				aw_addr <= i_s_axi_awaddr;
			end
			if (w_take) begin
				w_data <= i_s_axi_wdata;
				w_strb <= i_s_axi_wstrb;
			end
			// the answer code is fixed at the commit
			if (do_write) begin
				o_s_axi_bresp <= wr_hit ? `ITC_RESP_OKAY : `ITC_RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------
	// write address decode
	// ----------------------------------------
	// the status register is read only, so a write there is an error
	always @* begin
		case ({2'h0, wr_index})
			`ITC_IDX_SLOW_TRIM:  wr_hit = 1'b1;
			`ITC_IDX_RANGE_TRIM: wr_hit = 1'b1;
			default:             wr_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// trim and range registers
	// ----------------------------------------
	// factory values are taken on the first edge after reset release;
	// the bus stays closed until then so software cannot race the load
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			load_pending       <= 1'b1;
			o_slow_coarse_trim <= 8'h00;
			o_slow_fine_trim   <= 1'b0;
			o_fast_ref_trim    <= 4'h0;
			o_osc_range_select <= `ITC_RANGE_RESET;
			o_narrow_max_32k   <= `ITC_NARROW_RESET;
		end else if (load_pending) begin
			// one-shot capture of the factory trims
			load_pending       <= 1'b0;
			o_slow_coarse_trim <= i_factory_slow_coarse;
			o_slow_fine_trim   <= i_factory_slow_fine;
			o_fast_ref_trim    <= i_factory_fast_trim;
		end else if (do_write && w_strb[0]) begin
			// only byte lane 0 carries these eight-bit registers
			if ({2'h0, wr_index} == `ITC_IDX_SLOW_TRIM) begin
				o_slow_coarse_trim <= w_data[7:0];
			end
			// all four fields of the range word land together
			if ({2'h0, wr_index} == `ITC_IDX_RANGE_TRIM) begin
				o_narrow_max_32k   <= w_data[`ITC_NARROW_BIT];
				o_osc_range_select <= w_data[`ITC_RANGE_HI:`ITC_RANGE_LO];
				o_fast_ref_trim    <= w_data[`ITC_FAST_HI:`ITC_FAST_LO];
				o_slow_fine_trim   <= w_data[`ITC_SFINE_BIT];
			end
		end
	end

	// ----------------------------------------
	// range synchronisation and factor
	// ----------------------------------------
	// range handover lives in its own small module
	itc_range_sync #(
		.SYNC_CYCLES (SYNC_CYCLES)
	) u_range_sync (
		.i_clk_sys        (i_clk_sys),
		.i_rst_n          (i_rst_n),
		.i_range_select   (o_osc_range_select),
		.i_narrow_max_32k (o_narrow_max_32k),
		.o_range_status   (o_osc_range_status),
		.o_busy           (o_range_busy),
		.o_fll_factor     (o_fll_factor)
	);

	// ----------------------------------------
	// read data decode
	// ----------------------------------------
	// range field reads the status, never the value just written
	assign range_reg_rd = {o_narrow_max_32k, o_osc_range_status, o_fast_ref_trim, o_slow_fine_trim};

	always @* begin
		rd_word = 32'h00000000;
		rd_hit  = 1'b1;
		// every unmapped index reads zero with an error
		case ({2'h0, rd_index})
			`ITC_IDX_SLOW_TRIM: begin
				rd_word[7:0] = o_slow_coarse_trim;
			end
			`ITC_IDX_RANGE_TRIM: begin
				rd_word[7:0] = range_reg_rd;
			end
			`ITC_IDX_SYNC_STAT: begin
				rd_word[0] = o_range_busy;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// read channel sequencing
	// ----------------------------------------
	// rvalid stands until the master takes it
	always @* begin
		next_rvalid = o_s_axi_rvalid;
		if (ar_take) begin
			next_rvalid = 1'b1;
		end else if (o_s_axi_rvalid & i_s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		// one read in flight; address is refused while data waits
		next_arready = ~next_rvalid & ~load_pending;
	end

	// read channel flops
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid  <= 1'b0;
			o_s_axi_rdata   <= 32'h00000000;
			o_s_axi_rresp   <= `ITC_RESP_OKAY;
		end else begin
			o_s_axi_arready <= next_arready;
			o_s_axi_rvalid  <= next_rvalid;
			// data and code are frozen until rready
			if (ar_take) begin
				o_s_axi_rdata <= rd_word;
				o_s_axi_rresp <= rd_hit ? `ITC_RESP_OKAY : `ITC_RESP_SLVERR;
			end
		end
	end

endmodule
`default_nettype wire

/* verif/itc_trim_cfg_sva.sv */
// assertion checker for the trim and range configuration block
`timescale 1ns/1ns
`default_nettype none
module itc_trim_cfg_sva #(
	parameter SYNC_CYCLES = 4
) (
	// clock, reset and bus handshakes
	input wire logic        i_clk_sys, i_rst_n,
	input wire logic        i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready, o_s_axi_bvalid,
	input wire logic        i_s_axi_arvalid, o_s_axi_arready, o_s_axi_rvalid,
	input wire logic [1:0]  o_s_axi_rresp,
	// oscillator controls
	input wire logic [7:0]  o_slow_coarse_trim,
	input wire logic [1:0]  o_osc_range_select, o_osc_range_status,
	input wire logic        o_narrow_max_32k, o_range_busy,
	input wire logic [11:0] o_fll_factor
);
	// ----------------------------------------
	// factor table, index {narrow, range}
	// ----------------------------------------
	localparam logic [11:0] FTAB [8] = '{12'h280, 12'h500, 12'h780, 12'hA00, 12'h2DC, 12'h5B8, 12'h895, 12'hB71};
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_rst_zero; $rose(i_rst_n) |-> o_osc_range_status == 2'h0 && !o_narrow_max_32k; endproperty
	// factor only judged once range and narrowing have settled
	property p_fact; ($stable(o_osc_range_status) && $stable(o_narrow_max_32k))[*2]
		|-> o_fll_factor == FTAB[{o_narrow_max_32k, o_osc_range_status}]; endproperty
	// status holds through the sync count, then follows select (default count of 4)
	property p_range; $changed(o_osc_range_select) && !o_range_busy
		|-> $stable(o_osc_range_status)[*4] ##1 o_osc_range_status == o_osc_range_select; endproperty
	property p_busy; o_range_busy |-> ##[1:8] !o_range_busy; endproperty
	property p_trim; $changed(o_slow_coarse_trim) |-> $rose(o_s_axi_bvalid) || !$past(i_rst_n, 2); endproperty
	property p_wr; i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready |-> ##2 o_s_axi_bvalid;
	endproperty
	property p_rd; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid; endproperty
	property p_arblk; o_s_axi_rvalid |-> !o_s_axi_arready; endproperty

	a_rst_zero: assert property (p_rst_zero) else $error("range or narrow not zero");
	a_fact: assert property (p_fact) else $error("wrong factor");
	a_range: assert property (p_range) else $error("range status timing");
	a_busy: assert property (p_busy) else $error("busy stuck");
	a_trim: assert property (p_trim) else $error("trim moved without write");
	a_wr: assert property (p_wr) else $error("late write answer");
	a_rd: assert property (p_rd) else $error("late read answer");
	a_arblk: assert property (p_arblk) else $error("read taken during answer");

	// main scenarios
	cover property ($rose(o_range_busy));
	cover property (o_s_axi_rvalid && o_s_axi_rresp == 2'h2);
	cover property (o_narrow_max_32k && o_osc_range_status == 2'h3);
endmodule

bind itc_trim_cfg itc_trim_cfg_sva #(.SYNC_CYCLES(SYNC_CYCLES)) u_sva (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
	.i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid),
	.o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_arvalid(i_s_axi_arvalid),
	.o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid), .o_s_axi_rresp(o_s_axi_rresp),
	.o_slow_coarse_trim(o_slow_coarse_trim), .o_osc_range_select(o_osc_range_select),
	.o_osc_range_status(o_osc_range_status), .o_narrow_max_32k(o_narrow_max_32k), .o_range_busy(o_range_busy),
	.o_fll_factor(o_fll_factor));
`default_nettype wire

/* verif/itc_trim_cfg_tb_top.sv */
// self-checking bench for the trim and range configuration block
`timescale 1ns/1ns
`default_nettype none
module itc_trim_cfg_tb_top;
	localparam logic [7:0] A_SLOW = 8'h08, A_RNG = 8'h0C, A_STAT = 8'h1C;
	localparam logic [11:0] FTAB [8] = '{12'h280, 12'h500, 12'h780, 12'hA00, 12'h2DC, 12'h5B8, 12'h895, 12'hB71};
	logic        i_clk_sys = 1'b0, i_rst_n = 1'b0, f_fine = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  f_coarse = 8'h00, awaddr = 8'h00, araddr = 8'h00;
	logic [3:0]  f_fast = 4'h0, wstrb = 4'h0;
	logic [31:0] wdata = 32'h0;
	int          fails = 0, comparisons = 0, cyc = 0;
	wire         awready, wready, bvalid, arready, rvalid, fine, narrow, busy;
	wire [1:0]   bresp, rresp, sel, st;
	wire [3:0]   fast;
	wire [7:0]   coarse;
	wire [11:0]  factor;
	wire [31:0]  rdata;

	itc_trim_cfg u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_factory_slow_coarse(f_coarse),
		.i_factory_slow_fine(f_fine), .i_factory_fast_trim(f_fast), .i_s_axi_awaddr(awaddr), .i_s_axi_awprot(3'h0),
		.i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
		.i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arprot(3'h0), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .o_slow_coarse_trim(coarse), .o_slow_fine_trim(fine), .o_fast_ref_trim(fast),
		.o_osc_range_select(sel), .o_narrow_max_32k(narrow), .o_osc_range_status(st), .o_range_busy(busy),
		.o_fll_factor(factor));

	// ----------------------------------------
	// clock, watchdog, report
	// ----------------------------------------
	always #5 i_clk_sys = ~i_clk_sys;
	// a hang in any handshake wait ends here
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			test_done;
		end
	end
	task automatic test_done;
		begin
			$display("comparisons=%0d fails=%0d", comparisons, fails);
			if (fails == 0 && comparisons > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask

	// ----------------------------------------
	// bus master tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic aw, w;
		begin
			aw = 1'b0;
			w = 1'b0;
			@(posedge i_clk_sys);
			awaddr <= a;
			wdata <= d;
			wstrb <= s;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			// either channel may be taken first
			while (!(aw && w)) begin
				@(posedge i_clk_sys);
				if (awvalid && awready === 1'b1) begin
					aw = 1'b1;
					awvalid <= 1'b0;
				end
				if (wvalid && wready === 1'b1) begin
					w = 1'b1;
					wvalid <= 1'b0;
				end
			end
			do @(posedge i_clk_sys); while (bvalid !== 1'b1);
			bready <= 1'b0;
			chk(bresp, er);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		begin
			@(posedge i_clk_sys);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			do @(posedge i_clk_sys); while (arready !== 1'b1);
			arvalid <= 1'b0;
			do @(posedge i_clk_sys); while (rvalid !== 1'b1);
			rready <= 1'b0;
			chk(rdata, ed);
			chk(rresp, er);
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset(input logic [7:0] c, input logic fi, input logic [3:0] fa);
		begin
			f_coarse <= c;
			f_fine <= fi;
			f_fast <= fa;
			i_rst_n <= 1'b0;
			repeat (4) @(posedge i_clk_sys);
			i_rst_n <= 1'b1;
			rd(A_SLOW, {24'h0, c}, 2'h0);
			rd(A_RNG, {27'h0, fa, fi}, 2'h0);
			chk(factor, 12'h280);
			$display("reset test done");
		end
	endtask
	// every code with narrowing clear then set; status must lag the write
	task automatic t_range;
		logic [1:0] c, p;
		logic n;
		int k;
		begin
			p = 2'h0;
			for (int i = 0; i < 8; i++) begin
				c = 2'(i + 1);
				n = i[2];
				wr(A_RNG, {24'h0, n, c, 5'h07}, 4'h1, 2'h0);
				rd(A_RNG, {24'h0, n, p, 5'h07}, 2'h0);
				chk({sel, st, busy}, {c, p, 1'b1});
				k = 0;
				while (busy !== 1'b0 && k < 50) begin
					@(posedge i_clk_sys);
					k++;
				end
				repeat (2) @(posedge i_clk_sys);
				rd(A_RNG, {24'h0, n, c, 5'h07}, 2'h0);
				chk(factor, FTAB[{n, c}]);
				p = c;
			end
			$display("range test done");
		end
	endtask
	// software copies its own trims in; upper data bits and strobe-less writes ignored
	task automatic t_trim;
		begin
			wr(A_SLOW, 32'hFFFFFF5A, 4'hF, 2'h0);
			chk(coarse, 8'h5A);
			wr(A_RNG, 32'h1E, 4'h1, 2'h0);
			chk({fast, fine, narrow}, 6'h3C);
			wr(A_SLOW, 32'h11, 4'h0, 2'h0);
			rd(A_SLOW, 32'h5A, 2'h0);
			$display("trim test done");
		end
	endtask
	task automatic t_err;
		begin
			wr(A_RNG, 32'h60, 4'h1, 2'h0);
			rd(A_STAT, 32'h1, 2'h0);
			rd(8'h40, 32'h0, 2'h2);
			wr(8'h44, 32'hFF, 4'hF, 2'h2);
			wr(A_STAT, 32'h1, 4'hF, 2'h2);
			rd(A_STAT, 32'h0, 2'h0);
			rd(A_SLOW, 32'h5A, 2'h0);
			$display("error test done");
		end
	endtask

	initial begin
		t_reset(8'hC3, 1'b1, 4'h9);
		t_range;
		t_trim;
		t_err;
		t_reset(8'h3C, 1'b0, 4'h6);
		test_done;
	end
endmodule
`default_nettype wire
